// ---- core/dcm_pkg.sv ----
// Package with register map, reset values and carrier types for the correction and mixer bank.
`default_nettype none
package dcm_pkg;

	// Register offsets on the configuration port.
	localparam logic [4:0] ALARM_MASK_OFS          = 5'h07;
	localparam logic [4:0] OFFSET_CORR_A_OFS       = 5'h08;
	localparam logic [4:0] FIFO_PRESET_OFS_B_OFS   = 5'h09;
	localparam logic [4:0] OFFSET_CORR_C_OFS       = 5'h0A;
	localparam logic [4:0] OFFSET_CORR_D_OFS       = 5'h0B;
	localparam logic [4:0] GAIN_CORR_A_OFS         = 5'h0C;
	localparam logic [4:0] COARSE_MIX_GAIN_B_OFS   = 5'h0D;
	localparam logic [4:0] GAIN_CORR_C_OFS         = 5'h0E;
	localparam logic [4:0] OUT_DELAY_GAIN_D_OFS    = 5'h0F;
	localparam logic [4:0] PHASE_CORR_AB_OFS       = 5'h10;
	localparam logic [4:0] PHASE_CORR_CD_OFS       = 5'h11;
	localparam logic [4:0] OSC_PHASE_OFFSET_AB_OFS = 5'h12;
	localparam logic [4:0] OSC_PHASE_OFFSET_CD_OFS = 5'h13;
	localparam logic [4:0] OSC_FREQ_LOW_AB_OFS     = 5'h14;
	localparam int         REG_COUNT               = 14;

	// Writable bits and reset value of each register, index 0 at the first offset.
	localparam logic [15:0] WRITE_MASK [REG_COUNT] = '{
		16'hFFFF, 16'h1FFF, 16'hFFFF, 16'h1FFF, 16'h1FFF, 16'h07FF, 16'hF7FF,
		16'h07FF, 16'hF7FF, 16'h0FFF, 16'h0FFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};
	localparam logic [15:0] RESET_VAL [REG_COUNT] = '{
		16'hFFFF, 16'h0000, 16'h8000, 16'h0000, 16'h0000, 16'h0400, 16'h0400,
		16'h0400, 16'h0400, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

	// Field positions.
	localparam int OFFSET_MSB     = 12;
	localparam int GAIN_MSB       = 10;
	localparam int GAIN_FRAC_BITS = 10;
	localparam int PHASE_MSB      = 11;
	localparam int PHASE_FRAC     = 12;
	localparam int FIFO_OFS_LSB   = 13;
	localparam int CMIX_LSB       = 12;
	localparam int DELAY_AB_LSB   = 14;
	localparam int DELAY_CD_LSB   = 12;
	localparam int DELAY_DEPTH    = 4;

	// Alarm mask bit positions.
	localparam int ALM_ZERO_CHK   = 15;
	localparam int ALM_COLLISION  = 13;
	localparam int ALM_ONE_APART  = 12;
	localparam int ALM_TWO_APART  = 11;
	localparam int ALM_CONV_CLK   = 10;
	localparam int ALM_DATA_CLK   = 9;
	localparam int ALM_OUT_GONE   = 8;
	localparam int ALM_PATTERN    = 7;
	localparam int ALM_PLL        = 5;
	localparam int ALM_PARITY_LSB = 1;
	localparam logic [15:0] ALARM_USED = 16'hBFBE;

	// Sync groups and the bit of each select field that enables auto-sync on write.
	localparam int GRP_OFS_AB = 0;
	localparam int GRP_OFS_CD = 1;
	localparam int GRP_COR_AB = 2;
	localparam int GRP_COR_CD = 3;
	localparam int GRP_MIX_AB = 4;
	localparam int GRP_MIX_CD = 5;
	localparam int GRP_COUNT  = 6;
	localparam int SEL_REG_WRITE = 0;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [4:0]  addr;
		logic [15:0] wdata;
	} dcm_reg_req_t;

	typedef struct packed {
		logic [15:0] a;
		logic [15:0] b;
		logic [15:0] c;
		logic [15:0] d;
	} dcm_quad_t;

endpackage
`default_nettype wire

// ---- core/dcm_regs.sv ----
// Correction and mixer register bank with double-buffered groups and sample path.
`default_nettype none

// Behaviour
// - Alarm mask bit one masks its alarm, zero unmasks; all ones after reset.
// - Mask bits map to fixed alarms; bits 14, 6 and 0 unused.
// - Offsets are 13-bit LSB counts; writing A offset auto-syncs A and B.
// - Writing B offset alone leaves active offsets; host writes A last.
// - Writing C offset auto-syncs C and D; D alone does nothing.
// - On FIFO sync, the 3-bit preset loads the read pointer; reset 100.
// - Gains are unsigned 11-bit, binary point above bit 9; reset is unity.
// - Four coarse mixer enables combine into plus or minus n times fs/8.
// - A/B and C/D outputs each delayed 0 to 3 cycles by own field.
// - A/B phase times current B sample is added into A sample.
// - C/D phase times current D sample is added into C sample.
// - Writing A/B phase loads A gain, B gain and A/B phase together.
// - Writing C/D phase loads C gain, D gain and C/D phase together.
// - Phase offset adds to accumulator upper 16 bits to address tables.
// - Writing a path phase offset loads it with its whole frequency word.
// - Frequency word is 32-bit two's complement; A/B low half in own register.
// - Write auto-sync happens only when the group's write-source bit is set.
module dcm_regs (
	// Clock and reset.
	input  wire logic                         clk,
	input  wire logic                         sys_rst,
	// Register port from the serial configuration interface.
	input  wire dcm_pkg::dcm_reg_req_t        reg_req,
	output logic                              rd_valid_q,
	output logic [15:0]                       rdata_q,
	// Sync sources: select fields and events (bit 2 serial, 1 sync pin, 0 strobe).
	input  wire logic [5:0][3:0]              sync_sel,
	input  wire logic [2:0]                   sync_evt,
	input  wire logic                         fifo_sync,
	// Frequency word halves held outside this bank.
	input  wire logic [15:0]                  osc_freq_hi_ab,
	input  wire logic [15:0]                  osc_freq_lo_cd,
	input  wire logic [15:0]                  osc_freq_hi_cd,
	// Raw alarms and status clear.
	input  wire logic [15:0]                  alarm_raw,
	input  wire logic [15:0]                  alarm_clr,
	output logic [15:0]                       alarm_status_q,
	output logic                              alarm_pin_q,
	output logic                              out_shutdown_q,
	// Sample path.
	input  wire dcm_pkg::dcm_quad_t           samp_in,
	output dcm_pkg::dcm_quad_t                samp_out_q,
	output logic [15:0]                       nco_addr_ab_q,
	output logic [15:0]                       nco_addr_cd_q,
	output logic [3:0]                        cmix_mode_q,
	output logic [2:0]                        fifo_rd_ptr_q
);

	function automatic logic [15:0] gain_mul(input logic [15:0] x, input logic [10:0] g);
		logic signed [27:0] p;
		p = $signed(x) * $signed({1'b0, g});
		return p[dcm_pkg::GAIN_FRAC_BITS +: 16];
	endfunction

	function automatic logic [15:0] phase_mul(input logic [15:0] x, input logic [11:0] ph);
		logic signed [27:0] p;
		p = $signed(x) * $signed(ph);
		return p[dcm_pkg::PHASE_FRAC +: 16];
	endfunction

	function automatic logic [15:0] ofs_ext(input logic [12:0] o);
		return {{3{o[dcm_pkg::OFFSET_MSB]}}, o};
	endfunction

	logic [15:0] regs_q [dcm_pkg::REG_COUNT];
	logic [12:0] act_off_q [4];
	logic [10:0] act_gain_q [4];
	logic [11:0] act_phase_ab_q;
	logic [11:0] act_phase_cd_q;
	logic [15:0] act_posoff_ab_q;
	logic [15:0] act_posoff_cd_q;
	logic [31:0] act_freq_ab_q;
	logic [31:0] act_freq_cd_q;
	logic [31:0] acc_ab_q;
	logic [31:0] acc_cd_q;
	logic [31:0] pipe_ab_q [dcm_pkg::DELAY_DEPTH];
	logic [31:0] pipe_cd_q [dcm_pkg::DELAY_DEPTH];

	// Address decode.
	wire         in_map  = (reg_req.addr >= dcm_pkg::ALARM_MASK_OFS) &&
	                       (reg_req.addr <= dcm_pkg::OSC_FREQ_LOW_AB_OFS);
	wire [4:0]   idx_raw = reg_req.addr - dcm_pkg::ALARM_MASK_OFS;
	wire [3:0]   idx     = idx_raw[3:0];
	wire         wr_hit  = reg_req.wr && in_map;
	// Unmapped reads still answer, with zero, so the host never waits on a stray address.
	wire         rd_hit  = reg_req.rd && in_map;

	wire [15:0] mask_r = regs_q[0];
	wire [15:0] r_ofs_a = regs_q[1];
	wire [15:0] r_fifo_b = regs_q[2];
	wire [15:0] r_ofs_c = regs_q[3];
	wire [15:0] r_ofs_d = regs_q[4];
	wire [15:0] r_gain_a = regs_q[5];
	wire [15:0] r_cmix_b = regs_q[6];
	wire [15:0] r_gain_c = regs_q[7];
	wire [15:0] r_dly_d = regs_q[8];
	wire [15:0] r_ph_ab = regs_q[9];
	wire [15:0] r_ph_cd = regs_q[10];
	wire [15:0] r_po_ab = regs_q[11];
	wire [15:0] r_po_cd = regs_q[12];
	wire [15:0] r_fl_ab = regs_q[13];

	// Writes to the A offset, C offset, phase and phase offset registers are the triggers; writes to the others trigger no sync.
	wire [5:0] trig_wr;
	assign trig_wr[dcm_pkg::GRP_OFS_AB] = wr_hit && reg_req.addr == dcm_pkg::OFFSET_CORR_A_OFS;
	assign trig_wr[dcm_pkg::GRP_OFS_CD] = wr_hit && reg_req.addr == dcm_pkg::OFFSET_CORR_C_OFS;
	assign trig_wr[dcm_pkg::GRP_COR_AB] = wr_hit && reg_req.addr == dcm_pkg::PHASE_CORR_AB_OFS;
	assign trig_wr[dcm_pkg::GRP_COR_CD] = wr_hit && reg_req.addr == dcm_pkg::PHASE_CORR_CD_OFS;
	assign trig_wr[dcm_pkg::GRP_MIX_AB] =
		wr_hit && reg_req.addr == dcm_pkg::OSC_PHASE_OFFSET_AB_OFS;
	assign trig_wr[dcm_pkg::GRP_MIX_CD] =
		wr_hit && reg_req.addr == dcm_pkg::OSC_PHASE_OFFSET_CD_OFS;

	// Sync is one cycle after the trigger write, so the group loads the value just stored.
	logic [5:0] trig_wr_q;
	logic [5:0] grp_sync;
	always_comb begin
		for (int g = 0; g < dcm_pkg::GRP_COUNT; g++) begin
			grp_sync[g] = (trig_wr_q[g] && sync_sel[g][dcm_pkg::SEL_REG_WRITE]) ||
			              (|(sync_sel[g][3:1] & sync_evt));
		end
	end

	// Reserved bits are cut on the way in, so they read back as zero.
	wire [15:0] wr_word = reg_req.wdata & dcm_pkg::WRITE_MASK[idx];
	wire [15:0] rd_word = rd_hit ? regs_q[idx] : 16'h0000;

	// Register writes and readback.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int i = 0; i < dcm_pkg::REG_COUNT; i++) begin
				regs_q[i] <= dcm_pkg::RESET_VAL[i];
			end
			trig_wr_q  <= 6'h00;
			rd_valid_q <= 1'b0;
			rdata_q    <= 16'h0000;
		end else begin
			if (wr_hit) begin
				regs_q[idx] <= wr_word;
			end
			trig_wr_q  <= trig_wr;
			rd_valid_q <= reg_req.rd;
			rdata_q    <= rd_word;
		end
	end

	// Double-buffered active copies.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int i = 0; i < 4; i++) begin
				act_off_q[i]  <= 13'h0000;
				act_gain_q[i] <= dcm_pkg::RESET_VAL[5][dcm_pkg::GAIN_MSB:0];
			end
			act_phase_ab_q  <= 12'h000;
			act_phase_cd_q  <= 12'h000;
			act_posoff_ab_q <= 16'h0000;
			act_posoff_cd_q <= 16'h0000;
			act_freq_ab_q   <= 32'h00000000;
			act_freq_cd_q   <= 32'h00000000;
		end else begin
			if (grp_sync[dcm_pkg::GRP_OFS_AB]) begin
				act_off_q[0] <= r_ofs_a[dcm_pkg::OFFSET_MSB:0];
				act_off_q[1] <= r_fifo_b[dcm_pkg::OFFSET_MSB:0];
			end
			if (grp_sync[dcm_pkg::GRP_OFS_CD]) begin
				act_off_q[2] <= r_ofs_c[dcm_pkg::OFFSET_MSB:0];
				act_off_q[3] <= r_ofs_d[dcm_pkg::OFFSET_MSB:0];
			end
			if (grp_sync[dcm_pkg::GRP_COR_AB]) begin
				act_gain_q[0]  <= r_gain_a[dcm_pkg::GAIN_MSB:0];
				act_gain_q[1]  <= r_cmix_b[dcm_pkg::GAIN_MSB:0];
				act_phase_ab_q <= r_ph_ab[dcm_pkg::PHASE_MSB:0];
			end
			if (grp_sync[dcm_pkg::GRP_COR_CD]) begin
				act_gain_q[2]  <= r_gain_c[dcm_pkg::GAIN_MSB:0];
				act_gain_q[3]  <= r_dly_d[dcm_pkg::GAIN_MSB:0];
				act_phase_cd_q <= r_ph_cd[dcm_pkg::PHASE_MSB:0];
			end
			if (grp_sync[dcm_pkg::GRP_MIX_AB]) begin
				act_posoff_ab_q <= r_po_ab;
				act_freq_ab_q   <= {osc_freq_hi_ab, r_fl_ab};
			end
			if (grp_sync[dcm_pkg::GRP_MIX_CD]) begin
				act_posoff_cd_q <= r_po_cd;
				act_freq_cd_q   <= {osc_freq_hi_cd, osc_freq_lo_cd};
			end
		end
	end

	// Alarm status and masking.
	wire [15:0] alarm_live     = alarm_status_q & ~mask_r & dcm_pkg::ALARM_USED;
	wire        live_collision = alarm_live[dcm_pkg::ALM_COLLISION];
	wire        live_conv_clk  = alarm_live[dcm_pkg::ALM_CONV_CLK];
	wire        live_data_clk  = alarm_live[dcm_pkg::ALM_DATA_CLK];
	wire        stop_cause     = live_collision || live_conv_clk || live_data_clk;
	// A set and a clear in the same cycle leave the bit set, so no event is lost.
	wire [15:0] alarm_status_d = ((alarm_status_q & ~alarm_clr) | alarm_raw) &
	                             dcm_pkg::ALARM_USED;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			alarm_status_q <= 16'h0000;
			alarm_pin_q    <= 1'b0;
			out_shutdown_q <= 1'b0;
		end else begin
			alarm_status_q <= alarm_status_d;
			alarm_pin_q    <= |alarm_live;
			out_shutdown_q <= stop_cause && !mask_r[dcm_pkg::ALM_OUT_GONE];
		end
	end

	// Corrected samples; the sums wrap at 16 bits with no saturation.
	// unsigned gain scaling
	wire [15:0] corr_a = gain_mul(samp_in.a, act_gain_q[0]) +
	                     phase_mul(samp_in.b, act_phase_ab_q) + ofs_ext(act_off_q[0]);
	wire [15:0] corr_b = gain_mul(samp_in.b, act_gain_q[1]) + ofs_ext(act_off_q[1]);
	wire [15:0] corr_c = gain_mul(samp_in.c, act_gain_q[2]) +
	                     phase_mul(samp_in.d, act_phase_cd_q) + ofs_ext(act_off_q[2]);
	wire [15:0] corr_d = gain_mul(samp_in.d, act_gain_q[3]) + ofs_ext(act_off_q[3]);

	// The delay fields act at once; they belong to no sync group.
	wire [1:0] dly_ab = r_dly_d[dcm_pkg::DELAY_AB_LSB +: 2];
	wire [1:0] dly_cd = r_dly_d[dcm_pkg::DELAY_CD_LSB +: 2];
	wire [31:0] sel_ab = pipe_ab_q[dly_ab];
	wire [31:0] sel_cd = pipe_cd_q[dly_cd];

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int i = 0; i < dcm_pkg::DELAY_DEPTH; i++) begin
				pipe_ab_q[i] <= 32'h00000000;
				pipe_cd_q[i] <= 32'h00000000;
			end
			samp_out_q <= '0;
		end else begin
			pipe_ab_q[0] <= {corr_a, corr_b};
			pipe_cd_q[0] <= {corr_c, corr_d};
			for (int i = 1; i < dcm_pkg::DELAY_DEPTH; i++) begin
				pipe_ab_q[i] <= pipe_ab_q[i-1];
				pipe_cd_q[i] <= pipe_cd_q[i-1];
			end
			samp_out_q <= {sel_ab, sel_cd};
		end
	end

	// Oscillator accumulators; the word wraps, so negative words step backwards.
	wire [31:0] acc_ab_d      = acc_ab_q + act_freq_ab_q;
	wire [31:0] acc_cd_d      = acc_cd_q + act_freq_cd_q;
	wire [15:0] nco_addr_ab_d = acc_ab_q[31:16] + act_posoff_ab_q;
	wire [15:0] nco_addr_cd_d = acc_cd_q[31:16] + act_posoff_cd_q;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			acc_ab_q      <= 32'h00000000;
			acc_cd_q      <= 32'h00000000;
			nco_addr_ab_q <= 16'h0000;
			nco_addr_cd_q <= 16'h0000;
		end else begin
			acc_ab_q      <= acc_ab_d;
			acc_cd_q      <= acc_cd_d;
			nco_addr_ab_q <= nco_addr_ab_d;
			nco_addr_cd_q <= nco_addr_cd_d;
		end
	end

	// Coarse mixer enables and FIFO preset.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cmix_mode_q   <= 4'h0;
			fifo_rd_ptr_q <= dcm_pkg::RESET_VAL[2][dcm_pkg::FIFO_OFS_LSB +: 3];
		end else begin
			cmix_mode_q <= r_cmix_b[dcm_pkg::CMIX_LSB +: 4];
			if (fifo_sync) begin
				fifo_rd_ptr_q <= r_fifo_b[dcm_pkg::FIFO_OFS_LSB +: 3];
			end
		end
	end

endmodule
`default_nettype wire

// ---- dv/dcm_regs_properties.sv ----
// Port-level checker for the correction and mixer register bank.
`default_nettype none
module dcm_regs_properties (
	// Clock and reset.
	input wire logic                  clk,
	input wire logic                  sys_rst,
	// Register port.
	input wire dcm_pkg::dcm_reg_req_t reg_req,
	input wire logic                  rd_valid_q,
	input wire logic [15:0]           rdata_q,
	// FIFO preset and alarms.
	input wire logic                  fifo_sync,
	input wire logic [2:0]            fifo_rd_ptr_q,
	input wire logic [15:0]           alarm_raw,
	input wire logic [15:0]           alarm_clr,
	input wire logic [15:0]           alarm_status_q,
	input wire logic                  alarm_pin_q,
	input wire logic                  out_shutdown_q
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic [2:0] preset_q;
	wire logic  unmapped = reg_req.addr < 5'h07 || reg_req.addr > 5'h14;
	// Shadow of the preset field, so a load can be judged against the last write.
	always_ff @(posedge clk) begin
		if (sys_rst)
			preset_q <= 3'h4;
		else if (reg_req.wr && reg_req.addr == dcm_pkg::FIFO_PRESET_OFS_B_OFS)
			preset_q <= reg_req.wdata[15:13];
	end
	sequence s_answer; ##1 rd_valid_q; endsequence
	property p_rd_answer; reg_req.rd |-> s_answer; endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
	property p_rd_idle; !reg_req.rd |=> !rd_valid_q; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read answer without read");
	property p_rd_quiet; !rd_valid_q |-> rdata_q == 16'h0000; endproperty
	a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside answer");
	property p_unmapped; reg_req.rd && unmapped |-> s_answer ##0 rdata_q == 16'h0000; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_fifo_load; fifo_sync |=> fifo_rd_ptr_q == $past(preset_q); endproperty
	a_fifo_load: assert property (p_fifo_load) else $error("read pointer preset wrong");
	property p_fifo_hold; !fifo_sync |=> $stable(fifo_rd_ptr_q); endproperty
	a_fifo_hold: assert property (p_fifo_hold) else $error("read pointer moved");
	property p_status;
		1 |=> (alarm_status_q & $past((alarm_status_q & ~alarm_clr)
			| (alarm_raw & dcm_pkg::ALARM_USED))) == $past((alarm_status_q & ~alarm_clr)
			| (alarm_raw & dcm_pkg::ALARM_USED));
	endproperty
	a_status: assert property (p_status) else $error("alarm status lost");
	property p_unused; (alarm_status_q & ~dcm_pkg::ALARM_USED) == 16'h0000; endproperty
	a_unused: assert property (p_unused) else $error("unused alarm bit set");
	property p_pin; alarm_pin_q |-> $past(alarm_status_q) != 16'h0000; endproperty
	a_pin: assert property (p_pin) else $error("alarm pin without status");
	property p_shut; out_shutdown_q |-> ($past(alarm_status_q) & 16'h2600) != 16'h0000; endproperty
	a_shut: assert property (p_shut) else $error("shutdown without cause");
endmodule
bind dcm_regs dcm_regs_properties i_props (.clk(clk), .sys_rst(sys_rst), .reg_req(reg_req),
	.rd_valid_q(rd_valid_q), .rdata_q(rdata_q), .fifo_sync(fifo_sync),
	.fifo_rd_ptr_q(fifo_rd_ptr_q), .alarm_raw(alarm_raw), .alarm_clr(alarm_clr),
	.alarm_status_q(alarm_status_q), .alarm_pin_q(alarm_pin_q), .out_shutdown_q(out_shutdown_q));
`default_nettype wire

// ---- dv/dcm_host.sv ----
// Host-side model issuing register writes and reads on the configuration port.
`default_nettype none
module dcm_host (
	// Clock.
	input  wire logic                  clk,
	// Register port.
	output var dcm_pkg::dcm_reg_req_t  reg_req,
	input  wire logic                  rd_valid_q,
	input  wire logic [15:0]           rdata_q
);
	timeunit 1ns;
	timeprecision 1ps;
	initial reg_req = '0;
	// Idle address and data are inverted so a stale value is never mistaken for a request.
	task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
		@(negedge clk);
		reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge clk);
		reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask
	task automatic rd_reg(input logic [4:0] a, output logic [15:0] d, output logic ok);
		@(negedge clk);
		reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(negedge clk);
		reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 16'hFFFF};
		ok = rd_valid_q;
		d = rdata_q;
	endtask
endmodule
`default_nettype wire

// ---- dv/dcm_regs_test.sv ----
// Self-checking bench for the correction and mixer register bank.
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin errors++; \
	$display("BAD %s expected %h seen %h", n, e, s); end end
module dcm_regs_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic                  clk = 1'b0;
	logic                  sys_rst = 1'b1;
	logic [5:0][3:0]       sync_sel = {6{4'h1}};
	logic [2:0]            sync_evt = 3'h0;
	logic                  fifo_sync = 1'b0;
	logic [15:0]           freq_hi = 16'h0000;
	logic [15:0]           freq_lo = 16'h0000;
	logic [15:0]           alarm_raw = 16'h0000;
	logic [15:0]           alarm_clr = 16'h0000;
	dcm_pkg::dcm_quad_t    samp_in = {16'h0064, 16'h00C8, 16'h012C, 16'h0190};
	dcm_pkg::dcm_reg_req_t reg_req;
	dcm_pkg::dcm_quad_t    so;
	logic                  rv, pin, shut, ok;
	logic [15:0]           rdata, st, nco, nco_cd, d, x, p;
	logic [3:0]            cmix;
	logic [2:0]            ptr;
	int                    errors = 0;
	int                    num_checks = 0;
	initial begin
		forever #12.5 clk = ~clk;
	end
	dcm_host i_host (.clk(clk), .reg_req(reg_req), .rd_valid_q(rv), .rdata_q(rdata));
	dcm_regs i_dut (.clk(clk), .sys_rst(sys_rst), .reg_req(reg_req), .rd_valid_q(rv),
		.rdata_q(rdata), .sync_sel(sync_sel), .sync_evt(sync_evt), .fifo_sync(fifo_sync),
		.osc_freq_hi_ab(freq_hi), .osc_freq_lo_cd(freq_lo), .osc_freq_hi_cd(freq_hi),
		.alarm_raw(alarm_raw), .alarm_clr(alarm_clr), .alarm_status_q(st),
		.alarm_pin_q(pin), .out_shutdown_q(shut), .samp_in(samp_in), .samp_out_q(so),
		.nco_addr_ab_q(nco), .nco_addr_cd_q(nco_cd), .cmix_mode_q(cmix), .fifo_rd_ptr_q(ptr));
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic rst();
		sys_rst = 1'b1;
		cyc(12);
		sys_rst = 1'b0;
	endtask
	task automatic wc(input logic [4:0] a, input logic [15:0] v);
		i_host.wr_reg(a, v);
		cyc(6);
	endtask
	task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
		i_host.rd_reg(a, d, ok);
		`CHK("valid", 1'b1, ok)
		`CHK("rdata", e, d)
	endtask
	// The output settles two edges after the input plus the programmed delay.
	task automatic lat(input int ka, input int kc);
		int          n;
		int          na = 0;
		int          nc = 0;
		logic [15:0] xc;
		x = so.a;
		xc = so.c;
		samp_in.a = ~samp_in.a;
		samp_in.c = ~samp_in.c;
		for (n = 1; n < 10; n++) begin
			@(posedge clk);
			#1;
			if (na == 0 && so.a !== x) na = n;
			if (nc == 0 && so.c !== xc) nc = n;
		end
		`CHK("delay_ab", 2 + ka, na)
		`CHK("delay_cd", 2 + kc, nc)
	endtask
	task automatic alarm(input logic [15:0] m, input logic ep, input logic es);
		i_host.wr_reg(5'h07, m);
		alarm_clr = 16'hFFFF;
		cyc(1);
		alarm_clr = 16'h0000;
		alarm_raw = 16'h6000;
		cyc(1);
		alarm_raw = 16'h0000;
		cyc(3);
		`CHK("status", 16'h2000, st)
		`CHK("pin", ep, pin)
		`CHK("shutdown", es, shut)
	endtask
	task automatic finish_test();
		$display("Checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		rst();
		for (int i = 0; i < 14; i++) begin
			i_host.wr_reg(5'(i + 7), 16'hFFFF);
			rd_chk(5'(i + 7), dcm_pkg::WRITE_MASK[i]);
		end
		i_host.wr_reg(5'h15, 16'hFFFF);
		rd_chk(5'h15, 16'h0000);
		fifo_sync = 1'b1;
		cyc(1);
		fifo_sync = 1'b0;
		cyc(2);
		`CHK("fifo_ptr", 3'h7, ptr)
		`CHK("cmix", 4'hF, cmix)
		rst();
		for (int i = 0; i < 14; i++) rd_chk(5'(i + 7), dcm_pkg::RESET_VAL[i]);
		`CHK("unity", samp_in, so)
		wc(5'h09, 16'h0005);
		`CHK("out_b", 16'h00C8, so.b)
		wc(5'h08, 16'h0003);
		`CHK("out_a", 16'h0064 + 16'h0003, so.a)
		`CHK("out_b", 16'h00C8 + 16'h0005, so.b)
		wc(5'h0B, 16'h0007);
		`CHK("out_d", 16'h0190, so.d)
		wc(5'h0A, 16'h0001);
		`CHK("out_c", 16'h012C + 16'h0001, so.c)
		`CHK("out_d", 16'h0190 + 16'h0007, so.d)
		wc(5'h0C, 16'h0200);
		`CHK("out_a", 16'h0064 + 16'h0003, so.a)
		wc(5'h10, 16'h0800);
		`CHK("out_a", 16'h0032 - 16'h0064 + 16'h0003, so.a)
		`CHK("out_b", 16'h00C8 + 16'h0005, so.b)
		sync_sel[3] = 4'h0;
		i_host.wr_reg(5'h0E, 16'h0200);
		wc(5'h11, 16'h0400);
		`CHK("out_c", 16'h012C + 16'h0001, so.c)
		sync_sel[3] = 4'h2;
		sync_evt = 3'h1;
		cyc(1);
		sync_evt = 3'h0;
		cyc(6);
		`CHK("out_c", 16'h0096 + 16'h0064 + 16'h0001, so.c)
		sync_sel[3] = 4'h1;
		for (int k = 0; k < 4; k += 3) begin
			i_host.wr_reg(5'h0F, {2'(k), 2'(3 - k), 12'h400});
			wc(5'h11, 16'h0400);
			lat(k, 3 - k);
		end
		wc(5'h12, 16'h1234);
		`CHK("nco", 16'h1234, nco)
		p = 16'h0000;
		for (int j = 0; j < 2; j++) begin
			freq_hi = (j == 0) ? 16'h0002 : 16'hFFFF;
			wc(5'h14, 16'h0000);
			x = nco;
			cyc(4);
			`CHK("nco_hold", 16'(x + (p << 2)), nco)
			wc(5'h12, 16'h1234);
			x = nco;
			cyc(4);
			`CHK("nco_step", 16'(x + (freq_hi << 2)), nco)
			p = freq_hi;
		end
		freq_hi = 16'h0000;
		wc(5'h13, 16'h0ABC);
		`CHK("nco_cd", 16'h0ABC, nco_cd)
		freq_lo = 16'h8000;
		freq_hi = 16'h0001;
		wc(5'h13, 16'h0ABC);
		x = nco_cd;
		cyc(4);
		`CHK("nco_cd_step", 16'(x + 16'h0006), nco_cd)
		alarm(16'hFFFF, 1'b0, 1'b0);
		alarm(16'h0000, 1'b1, 1'b1);
		alarm(16'h0100, 1'b1, 1'b0);
		alarm(16'h2000, 1'b0, 1'b0);
		finish_test();
	end
endmodule
`default_nettype wire
